// ---- core/lpg_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpg_gate
  import lpg_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] modeEnable,
  input wire logic fwIdle,
  input wire logic uartBusy,
  input wire logic uartSwManaged,
  input wire logic spiBusy,
  input wire logic i2cBusy,
  input wire logic adcBusy,
  input wire logic flashOpen,
  input wire logic osTimerCounting,
  input wire logic dmaSwManaged,
  input wire logic advertising,
  input wire logic connected,
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic sleepWake,
  input wire logic backupWake,
  output logic [3:0] lpMode,
  output logic [12:0] periphRun,
  output logic [12:0] periphRestore,
  output logic [12:0] periphCounterClear,
  output logic seedInvalid,
  output logic coldBootNeeded,
  output logic wakePulse
);

  // ==========================================================
  // pin synchronisers
  // wake pins are asynchronous, two flops before any logic reads them
  logic pinASync, pinBSync;
  lpg_sync2 #(
    .WIDTH(1)
  ) u_syncA (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(wake_pin_a),
    .syncOut(pinASync)
  );
  lpg_sync2 #(
    .WIDTH(1)
  ) u_syncB (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(wake_pin_b),
    .syncOut(pinBSync)
  );

  // ==========================================================
  // blocking conditions
  logic commonBlock, flashBlock, pinBlock, allowSleep, allowBackup, allowDeep;
  // a wake pin already high would end the mode at once, so it holds entry off
  assign pinBlock = pinASync | pinBSync;
  // flash session only matters on the flash variant
  assign flashBlock = HAS_FLASH & flashOpen;
  // serial, adc and flash activity block all modes
  assign commonBlock = uartBusy | spiBusy | i2cBusy | adcBusy | flashBlock | pinBlock | ~fwIdle;
  assign allowSleep = modeEnable[LPG_EN_SLEEP] & ~commonBlock;
  // os timers keep backup and deeper modes out
  assign allowBackup = modeEnable[LPG_EN_BACKUP] & ~commonBlock & ~osTimerCounting & ~connected;
  assign allowDeep = modeEnable[LPG_EN_DEEP] & ~commonBlock & ~osTimerCounting & ~connected & ~advertising;

  // deepest allowed mode wins
  lpg_mode_t target;
  always_comb begin
    if (allowDeep) begin
      target = LPG_DEEP;
    end else if (allowBackup) begin
      target = LPG_BACKUP;
    end else if (allowSleep) begin
      target = LPG_SLEEP;
    end else begin
      target = LPG_ACTIVE;
    end
  end

  // ==========================================================
  // entry decision and wake state machine
  lpg_state_t state;
  lpg_mode_t mode, pending;
  logic [3:0] checkCnt;
  logic checkDone;
  logic wakeHit;

  // last check cycle of the decision
  assign checkDone = (checkCnt == LPG_CHECK_CYCLES - 4'h1);

  // wake sources per mode
  always_comb begin
    case (mode)
      LPG_DEEP: wakeHit = pinASync | pinBSync;
      LPG_BACKUP: wakeHit = pinASync | pinBSync | backupWake;
      LPG_SLEEP: wakeHit = pinASync | pinBSync | sleepWake;
      default: wakeHit = 1'b0;
    endcase
  end

  // state register: run, decision, low power, wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= LPG_ST_RUN;
    end else begin
      case (state)
        LPG_ST_RUN: begin
          // automatic entry, no command needed
          if (target != LPG_ACTIVE) begin
            state <= LPG_ST_CHECK;
          end
        end
        LPG_ST_CHECK: begin
          // any change of allowed mode during the decision aborts it
          if (target != pending) begin
            state <= LPG_ST_RUN;
          end else if (checkDone) begin
            state <= LPG_ST_LOW;
          end
        end
        LPG_ST_LOW: begin
          if (wakeHit) begin
            state <= LPG_ST_WAKE;
          end
        end
        LPG_ST_WAKE: begin
          state <= LPG_ST_RUN;
        end
        default: begin
          state <= LPG_ST_RUN;
        end
      endcase
    end
  end

  // mode chosen at the start of the decision, held through it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= LPG_ACTIVE;
    end else if (state == LPG_ST_RUN && target != LPG_ACTIVE) begin
      pending <= target;
    end
  end

  // decision counter restarts with every new decision
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      checkCnt <= 4'h0;
    end else if (state != LPG_ST_CHECK) begin
      checkCnt <= 4'h0;
    end else if (!checkDone) begin
      checkCnt <= checkCnt + 4'h1;
    end
  end

  // committed mode: set when the decision completes, active again on wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= LPG_ACTIVE;
    end else if (state == LPG_ST_CHECK && target == pending && checkDone) begin
      mode <= pending;
    end else if (state == LPG_ST_WAKE) begin
      mode <= LPG_ACTIVE;
    end
  end

  // ==========================================================
  // peripheral run gates, next value from mode
  logic [12:0] next_periphRun;
  always_comb begin
    next_periphRun = LPG_RUN_ALL;
    case (mode)
      LPG_SLEEP: begin
        // serial, adc, pwm, rng, timers, watchdog, dma, debug halted
        next_periphRun = 13'h0000;
        next_periphRun[LPG_P_OST] = 1'b1;
        next_periphRun[LPG_P_RTC] = 1'b1;
        next_periphRun[LPG_P_FLASH] = 1'b0;
      end
      LPG_BACKUP: begin
        next_periphRun = 13'h0000;
        next_periphRun[LPG_P_RTC] = 1'b1;
      end
      LPG_DEEP: next_periphRun = 13'h0000;
      default: next_periphRun = LPG_RUN_ALL;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      periphRun <= LPG_RUN_ALL;
    end else begin
      periphRun <= next_periphRun;
    end
  end

  // ==========================================================
  // restore / clear strobes at wake
  logic wakeNow, deepWake;
  logic [12:0] next_periphRestore, next_periphCounterClear;
  assign wakeNow = (state == LPG_ST_WAKE);
  assign deepWake = wakeNow & (mode == LPG_DEEP);

  // deep sleep keeps nothing, so nothing is restored
  always_comb begin
    next_periphRestore = 13'h0000;
    next_periphCounterClear = 13'h0000;
    if (wakeNow && !deepWake) begin
      next_periphRestore[LPG_P_UART] = uartSwManaged;
      next_periphRestore[LPG_P_SPI] = 1'b1;
      next_periphRestore[LPG_P_I2C] = 1'b1;
      next_periphRestore[LPG_P_PWM] = 1'b1;
      next_periphRestore[LPG_P_ADC] = 1'b1;
      next_periphRestore[LPG_P_RNG] = 1'b0;
      next_periphRestore[LPG_P_TMR] = 1'b1;
      next_periphRestore[LPG_P_WDT] = 1'b1;
      next_periphRestore[LPG_P_DMA] = dmaSwManaged;
      next_periphCounterClear[LPG_P_TMR] = 1'b1;
      next_periphCounterClear[LPG_P_WDT] = 1'b1;
    end
  end

  // restore and clear strobes, one cycle each
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      periphRestore <= 13'h0000;
      periphCounterClear <= 13'h0000;
    end else begin
      periphRestore <= next_periphRestore;
      periphCounterClear <= next_periphCounterClear;
    end
  end

  // wake pulse marks the first active cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakePulse <= 1'b0;
    end else begin
      wakePulse <= wakeNow;
    end
  end

  // seed lost in any low power mode, sticky until reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seedInvalid <= 1'b0;
    end else if (state == LPG_ST_LOW) begin
      seedInvalid <= 1'b1;
    end
  end

  // cold boot flagged after a deep sleep wake, cleared only by reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      coldBootNeeded <= 1'b0;
    end else if (deepWake) begin
      coldBootNeeded <= 1'b1;
    end
  end

  assign lpMode = mode;

endmodule

// ==========================================================
// two-flop synchroniser for inputs from outside the clock domain
module lpg_sync2
  import lpg_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // first stage may go metastable; only the second stage is read
  logic [WIDTH-1:0] meta;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- core/lpg_pkg.sv ----
package lpg_pkg;
  // ==========================================================
  // low power modes
  typedef enum logic [3:0] {
    LPG_ACTIVE = 4'h1,
    LPG_SLEEP = 4'h2,
    LPG_BACKUP = 4'h4,
    LPG_DEEP = 4'h8
  } lpg_mode_t;
  // ==========================================================
  // entry decision states
  typedef enum logic [3:0] {
    LPG_ST_RUN = 4'h1,
    LPG_ST_CHECK = 4'h2,
    LPG_ST_LOW = 4'h4,
    LPG_ST_WAKE = 4'h8
  } lpg_state_t;
  // ==========================================================
  // peripheral gate bit positions
  localparam int LPG_P_UART = 0;
  localparam int LPG_P_SPI = 1;
  localparam int LPG_P_I2C = 2;
  localparam int LPG_P_PWM = 3;
  localparam int LPG_P_ADC = 4;
  localparam int LPG_P_RNG = 5;
  localparam int LPG_P_TMR = 6;
  localparam int LPG_P_OST = 7;
  localparam int LPG_P_RTC = 8;
  localparam int LPG_P_WDT = 9;
  localparam int LPG_P_DMA = 10;
  localparam int LPG_P_SWD = 11;
  localparam int LPG_P_FLASH = 12;
  localparam int LPG_NPERIPH = 13;
  // enable-mask bit positions
  localparam int LPG_EN_SLEEP = 0;
  localparam int LPG_EN_BACKUP = 1;
  localparam int LPG_EN_DEEP = 2;
  // cycles spent re-checking conditions before committing to entry
  localparam logic [3:0] LPG_CHECK_CYCLES = 4'h2;
  // reset value of the gate vector: all peripherals running
  localparam logic [12:0] LPG_RUN_ALL = 13'h1FFF;
endpackage

// ---- tb/lpg_gate_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpg_gate_chk
  import lpg_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] modeEnable,
  input wire logic fwIdle,
  input wire logic uartBusy,
  input wire logic spiBusy,
  input wire logic i2cBusy,
  input wire logic adcBusy,
  input wire logic flashOpen,
  input wire logic osTimerCounting,
  input wire logic advertising,
  input wire logic connected,
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic sleepWake,
  input wire logic [3:0] lpMode,
  input wire logic [12:0] periphRun,
  input wire logic [12:0] periphRestore,
  input wire logic [12:0] periphCounterClear,
  input wire logic seedInvalid,
  input wire logic coldBootNeeded,
  input wire logic wakePulse
);
  // ==========================================================
  // helper terms
  wire blk = uartBusy | spiBusy | i2cBusy | adcBusy | !fwIdle | (HAS_FLASH & flashOpen);
  wire ok = modeEnable[LPG_EN_SLEEP] & !blk & !wake_pin_a & !wake_pin_b & !sleepWake;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // entry decision
  entry_blocked_a:
    assert property (lpMode == LPG_ACTIVE && blk ##1 blk |=> lpMode == LPG_ACTIVE) else $error("entry while blocked");
  backup_refused_a:
    assert property (lpMode == LPG_ACTIVE && osTimerCounting ##1 osTimerCounting |=> lpMode inside {LPG_ACTIVE, LPG_SLEEP})
    else $error("backup entered while os timer counts");
  auto_entry_a:
    assert property ((lpMode == LPG_ACTIVE && ok)[*6] |=> lpMode != LPG_ACTIVE) else $error("no automatic entry");
  // ==========================================================
  // gating in low power
  sleep_gates_a:
    assert property (lpMode == LPG_SLEEP ##1 lpMode == LPG_SLEEP |-> (periphRun & 13'h0E77) == 13'h0000
      && periphRun[LPG_P_OST]) else $error("sleep gating wrong");
  backup_gates_a:
    assert property (lpMode == LPG_BACKUP ##1 lpMode == LPG_BACKUP |-> (periphRun & 13'h0EF7) == 13'h0000)
    else $error("backup gating wrong");
  deep_gates_a:
    assert property (lpMode == LPG_DEEP ##1 lpMode == LPG_DEEP |-> periphRun == 13'h0000) else $error("deep gating wrong");
  deep_stays_a:
    assert property ((lpMode == LPG_DEEP && !wake_pin_a && !wake_pin_b)[*3] |=> lpMode == LPG_DEEP)
    else $error("deep left without wake pin");
  // ==========================================================
  // wake-up
  wake_pulse_a:
    assert property ($rose(lpMode == LPG_ACTIVE) |-> wakePulse ##1 !wakePulse) else $error("wake pulse wrong");
  sleep_restore_a:
    assert property (wakePulse && $past(lpMode) == LPG_SLEEP |-> periphRestore[LPG_P_SPI] && periphRestore[LPG_P_I2C]
      && !periphRestore[LPG_P_RNG] && periphCounterClear[LPG_P_TMR] && periphCounterClear[LPG_P_WDT])
    else $error("restore after sleep wrong");
  deep_cold_a:
    assert property (wakePulse && $past(lpMode) == LPG_DEEP |-> periphRestore == 13'h0000 ##1 coldBootNeeded)
    else $error("deep wake kept state");
  seed_lost_a:
    assert property (lpMode != LPG_ACTIVE |=> seedInvalid) else $error("seed not invalidated");
endmodule
bind lpg_gate lpg_gate_chk #(.HAS_FLASH(HAS_FLASH)) u_chk (.*);
`default_nettype wire

// ---- tb/tb_low_power_peripheral_gating.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_low_power_peripheral_gating;
  import lpg_pkg::*;
  logic core_clk = 0, nrst = 0, fwIdle = 1, uartBusy = 0, uartSwManaged = 1, spiBusy = 0, i2cBusy = 0, adcBusy = 0;
  logic flashOpen = 0, osTimerCounting = 0, dmaSwManaged = 0, advertising = 0, connected = 0;
  logic wake_pin_a = 0, wake_pin_b = 0, sleepWake = 0, backupWake = 0;
  logic [2:0] modeEnable = 3'h0;
  logic [3:0] lpMode;
  logic [12:0] periphRun, periphRestore, periphCounterClear, rst, clr;
  logic seedInvalid, coldBootNeeded, wakePulse;
  int errors = 0, checks_done = 0, cyc = 0;
  lpg_gate u_dut (.*);
  // ==========================================================
  // clock, timeout, helpers
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // enable modes and wait for the mode change
  task automatic enter(logic [2:0] en, logic [3:0] m, logic [12:0] run);
    modeEnable = en;
    for (int i = 0; i < 20 && lpMode === LPG_ACTIVE; i++) step(1);
    step(2);
    chk("lpMode", 13'(m), 13'(lpMode));
    chk("periphRun", run, periphRun);
  endtask
  // wait for the wake pulse and keep the pulses
  task automatic wait_wake;
    modeEnable = 3'h0;
    for (int i = 0; i < 20 && wakePulse !== 1'b1; i++) step(1);
    rst = periphRestore;
    clr = periphCounterClear;
    chk("wakePulse", 13'h1, 13'(wakePulse));
    chk("lpMode", 13'(LPG_ACTIVE), 13'(lpMode));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_block;
    for (int i = 0; i < 8; i++) begin
      modeEnable = i == 6 ? 3'h2 : i == 7 ? 3'h4 : 3'h7;
      step(1);
      {advertising, connected, fwIdle, flashOpen, adcBusy, i2cBusy, spiBusy, uartBusy} = 8'h20 ^ (8'h01 << i);
      step(8);
      chk("lpMode", 13'(LPG_ACTIVE), 13'(lpMode));
      {advertising, connected, fwIdle, flashOpen, adcBusy, i2cBusy, spiBusy, uartBusy} = 8'h20;
      modeEnable = 3'h0;
      step(1);
    end
  endtask
  task automatic t_sleep_backup;
    for (int p = 0; p < 2; p++) begin
      {osTimerCounting, uartSwManaged, advertising, dmaSwManaged} = p ? 4'h3 : 4'hC;
      // sleep pass: os timer counting, uart sw-managed; backup pass: advertising, dma sw-managed
      enter(3'h7, p ? LPG_BACKUP : LPG_SLEEP, p ? 13'h0100 : 13'h0180);
      if (p) backupWake = 1;
      else sleepWake = 1;
      wait_wake();
      {sleepWake, backupWake} = 2'h0;
      chk("restore", p ? 13'h2 : 13'h4, 13'({rst[LPG_P_UART], rst[LPG_P_DMA], rst[LPG_P_RNG]}));
      chk("restore", 13'hF, 13'({rst[LPG_P_SPI], rst[LPG_P_I2C], rst[LPG_P_ADC], rst[LPG_P_PWM]}));
      chk("counterClear", 13'h3, 13'({clr[LPG_P_TMR], clr[LPG_P_WDT]}));
    end
    {osTimerCounting, advertising} = 2'h0;
  endtask
  task automatic t_deep;
    enter(3'h7, LPG_DEEP, 13'h0000);
    {sleepWake, backupWake} = 2'h3;
    step(8);
    chk("lpMode", 13'(LPG_DEEP), 13'(lpMode));
    wake_pin_b = 1;
    wait_wake();
    {wake_pin_b, sleepWake, backupWake} = 3'h0;
    chk("periphRestore", 13'h0000, rst);
    chk("coldBootNeeded", 13'h1, 13'(coldBootNeeded));
    chk("seedInvalid", 13'h1, 13'(seedInvalid));
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    step(5);
    nrst = 1;
    step(1);
    t_block();
    t_sleep_backup();
    t_deep();
    report_and_stop();
  end
endmodule
`default_nettype wire
